// file: design/mss_consts.vh
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH
// register offsets (word index)
`define MSS_REG_CTRL        4'h0
`define MSS_REG_VOLT        4'h1
`define MSS_REG_PRE_TIME    4'h2
`define MSS_REG_PRE_LEVEL   4'h3
`define MSS_REG_BLANK_TIME  4'h4
`define MSS_REG_BRAKE_TIME  4'h5
`define MSS_REG_BRAKE_LEVEL 4'h6
`define MSS_REG_ONSET_FREQ  4'h7
`define MSS_REG_BASE_FREQ   4'h8
`define MSS_REG_DWELL_FREQ  4'h9
`define MSS_REG_BUS_LIMIT   4'hA
`define MSS_REG_STATUS      4'hB
`define MSS_REG_OUT_FREQ    4'hC
`define MSS_REG_OUT_VOLT    4'hD
// ctrl fields
`define MSS_CTRL_START_BIT  0
`define MSS_CTRL_STOP_LO    1
`define MSS_CTRL_STOP_HI    3
`define MSS_CTRL_STALL_BIT  4
// reset values: volts, percent, 0.01 s, 0.01 Hz
`define MSS_RST_VOLT        16'h00DC
`define MSS_RST_PRE_TIME    16'h0000
`define MSS_RST_PRE_LEVEL   16'h0032
`define MSS_RST_BLANK_TIME  16'h000A
`define MSS_RST_BRAKE_TIME  16'h0064
`define MSS_RST_BRAKE_LEVEL 16'h0032
`define MSS_RST_ONSET_FREQ  16'h01F4
`define MSS_RST_BASE_FREQ   16'h1770
`define MSS_RST_BUS_LIMIT   16'h02EE
`define MSS_VOLT_MIN        16'h00B4
`define MSS_VOLT_MAX        16'h01E0
// one time unit is 10 ms at 100 MHz
`define MSS_TICK_NS         10000000
`define MSS_CLK_NS          10
`define MSS_TICK_CYCLES     (`MSS_TICK_NS / `MSS_CLK_NS)
// states
`define MSS_ST_IDLE   3'h0
`define MSS_ST_PRE    3'h1
`define MSS_ST_RUN    3'h2
`define MSS_ST_DECEL  3'h3
`define MSS_ST_BLANK  3'h4
`define MSS_ST_BRAKE  3'h5
`endif

// file: design/mss_sequencer.v
// Contract
// - base-frequency output equals nameplate voltage, 180..480 V, default 220
// - above base, output limited to supply voltage when supply is lower
// - nameplate zero: scale from supply voltage captured while idle
// - start method 0: ramp directly to target on run while idle
// - start method 1: DC injection for pre-start time, then accelerate
// - pre-start injection level percent of rated current, default 50
// - stop method 0: ramp to 0 Hz then stop output
// - stop method 1: ramp to onset frequency then DC injection brake
// - output blocked for blanking time before injection braking
// - injection braking held for braking duration, default 1.00
// - braking magnitude percent of rated current, default 50
// - braking begins when decelerating frequency reaches onset, default 5.00 Hz
// - dwell below onset frequency is skipped, only injection braking
// - stop method 2: block output at once, motor coasts
// - stop method 3: flux braking ramp, energy dissipated in motor
// - flux braking only in deceleration, wins over stall prevention bit 4
// - stop method 4: bus above threshold slows or reverses the ramp
// - power braking only in deceleration, wins over stall prevention bit 4
// - power braking stop may exceed configured deceleration time
// - base frequency default 60.00 Hz
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "mss_consts.vh"
module mss_sequencer #(
  parameter TICK_CYCLES = `MSS_TICK_CYCLES,
  parameter RAMP_STEP = 16'h0001
)(
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // commands and measurements
  input wire run_i,
  input wire [15:0] target_freq_i,
  input wire [15:0] supply_volt_i,
  input wire [15:0] bus_volt_i,
  // drive outputs
  output reg [15:0] out_freq_o,
  output reg [15:0] out_volt_o,
  output reg out_enable_o,
  output reg inject_o,
  output reg [7:0] inject_level_o,
  output reg flux_brake_o,
  output reg stall_active_o
);
  reg run_s1, run_s2;
  reg [15:0] tgt_s1, tgt_s2, sup_s1, sup_s2, bus_s1, bus_s2;
  reg [4:0] ctrl;
  reg [15:0] volt_set, pre_time, pre_level, blank_time, brake_time, brake_level;
  reg [15:0] onset_freq, base_freq, dwell_freq, bus_limit;
  reg [15:0] idle_supply;
  reg [2:0] state;
  reg [2:0] stop_mode;
  reg [15:0] timer;
  reg [15:0] freq;
  reg [15:0] next_volt;
  reg [31:0] scaled;
  reg [15:0] ref_volt;
  wire tick;
  wire stop_start = ctrl[`MSS_CTRL_START_BIT];
  wire [2:0] stop_sel = ctrl[`MSS_CTRL_STOP_HI:`MSS_CTRL_STOP_LO];
  wire stall_en = ctrl[`MSS_CTRL_STALL_BIT];

  function [15:0] clamp_volt;
    input [15:0] v;
    begin
      if (v == 16'h0000)
        clamp_volt = 16'h0000;
      else if (v < `MSS_VOLT_MIN)
        clamp_volt = `MSS_VOLT_MIN;
      else if (v > `MSS_VOLT_MAX)
        clamp_volt = `MSS_VOLT_MAX;
      else
        clamp_volt = v;
    end
  endfunction

  mss_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .tick_o(tick)
  );

  // pins come from outside the clock domain
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
      tgt_s1 <= 16'h0000;
      tgt_s2 <= 16'h0000;
      sup_s1 <= 16'h0000;
      sup_s2 <= 16'h0000;
      bus_s1 <= 16'h0000;
      bus_s2 <= 16'h0000;
    end
    else
    begin
      run_s1 <= run_i;
      run_s2 <= run_s1;
      tgt_s1 <= target_freq_i;
      tgt_s2 <= tgt_s1;
      sup_s1 <= supply_volt_i;
      sup_s2 <= sup_s1;
      bus_s1 <= bus_volt_i;
      bus_s2 <= bus_s1;
    end
  end

  // register writes
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl <= 5'h00;
      volt_set <= `MSS_RST_VOLT;
      pre_time <= `MSS_RST_PRE_TIME;
      pre_level <= `MSS_RST_PRE_LEVEL;
      blank_time <= `MSS_RST_BLANK_TIME;
      brake_time <= `MSS_RST_BRAKE_TIME;
      brake_level <= `MSS_RST_BRAKE_LEVEL;
      onset_freq <= `MSS_RST_ONSET_FREQ;
      base_freq <= `MSS_RST_BASE_FREQ;
      dwell_freq <= 16'h0000;
      bus_limit <= `MSS_RST_BUS_LIMIT;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `MSS_REG_CTRL: ctrl <= wdata_i[4:0];
        `MSS_REG_VOLT: volt_set <= clamp_volt(wdata_i);
        `MSS_REG_PRE_TIME: pre_time <= wdata_i;
        `MSS_REG_PRE_LEVEL: pre_level <= wdata_i;
        `MSS_REG_BLANK_TIME: blank_time <= wdata_i;
        `MSS_REG_BRAKE_TIME: brake_time <= wdata_i;
        `MSS_REG_BRAKE_LEVEL: brake_level <= wdata_i;
        `MSS_REG_ONSET_FREQ: onset_freq <= wdata_i;
        `MSS_REG_BASE_FREQ: base_freq <= wdata_i;
        `MSS_REG_DWELL_FREQ: dwell_freq <= wdata_i;
        `MSS_REG_BUS_LIMIT: bus_limit <= wdata_i;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // register reads, data one cycle later
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      case (addr_i)
        `MSS_REG_CTRL: rdata_o <= {11'h000, ctrl};
        `MSS_REG_VOLT: rdata_o <= volt_set;
        `MSS_REG_PRE_TIME: rdata_o <= pre_time;
        `MSS_REG_PRE_LEVEL: rdata_o <= pre_level;
        `MSS_REG_BLANK_TIME: rdata_o <= blank_time;
        `MSS_REG_BRAKE_TIME: rdata_o <= brake_time;
        `MSS_REG_BRAKE_LEVEL: rdata_o <= brake_level;
        `MSS_REG_ONSET_FREQ: rdata_o <= onset_freq;
        `MSS_REG_BASE_FREQ: rdata_o <= base_freq;
        `MSS_REG_DWELL_FREQ: rdata_o <= dwell_freq;
        `MSS_REG_BUS_LIMIT: rdata_o <= bus_limit;
        `MSS_REG_STATUS: rdata_o <= {9'h000, stop_mode, 1'b0, state};
        `MSS_REG_OUT_FREQ: rdata_o <= out_freq_o;
        `MSS_REG_OUT_VOLT: rdata_o <= out_volt_o;
        default: rdata_o <= 16'h0000;
      endcase
    end
    else
      rdata_o <= 16'h0000;
  end

  // idle supply sample for auto scaling
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      idle_supply <= 16'h0000;
    else if (state == `MSS_ST_IDLE)
      idle_supply <= sup_s2;
  end

  // voltage scaling: linear up to base, flat above
  always @*
  begin
    ref_volt = (volt_set == 16'h0000) ? idle_supply : volt_set;
    scaled = 32'h0000_0000;
    if (base_freq == 16'h0000 || freq >= base_freq)
    begin
      next_volt = ref_volt;
      if (freq > base_freq && sup_s2 < ref_volt)
        next_volt = sup_s2;
    end
    else
    begin
      scaled = (ref_volt * freq) / base_freq;
      next_volt = scaled[15:0];
    end
  end

  // sequencer; mode is latched so a change mid-sequence waits
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= `MSS_ST_IDLE;
      stop_mode <= 3'h0;
      timer <= 16'h0000;
      freq <= 16'h0000;
      out_freq_o <= 16'h0000;
      out_volt_o <= 16'h0000;
      out_enable_o <= 1'b0;
      inject_o <= 1'b0;
      inject_level_o <= 8'h00;
      flux_brake_o <= 1'b0;
      stall_active_o <= 1'b0;
    end
    else
    begin
      out_freq_o <= freq;
      out_volt_o <= out_enable_o ? next_volt : 16'h0000;
      case (state)
        `MSS_ST_IDLE:
        begin
          out_enable_o <= 1'b0;
          inject_o <= 1'b0;
          flux_brake_o <= 1'b0;
          stall_active_o <= 1'b0;
          freq <= 16'h0000;
          if (run_s2)
          begin
            stop_mode <= stop_sel;
            timer <= pre_time;
            if (stop_start)
            begin
              state <= `MSS_ST_PRE;
              inject_o <= 1'b1;
              inject_level_o <= pre_level[7:0];
            end
            else
            begin
              state <= `MSS_ST_RUN;
              out_enable_o <= 1'b1;
            end
          end
        end
        `MSS_ST_PRE:
        begin
          if (timer == 16'h0000)
          begin
            inject_o <= 1'b0;
            out_enable_o <= 1'b1;
            state <= `MSS_ST_RUN;
          end
          else if (tick)
            timer <= timer - 16'h0001;
        end
        `MSS_ST_RUN:
        begin
          if (!run_s2)
          begin
            if (stop_mode == 3'h2)
            begin
              out_enable_o <= 1'b0;
              // volts must drop with the enable, not a cycle later
              out_volt_o <= 16'h0000;
              freq <= 16'h0000;
              state <= `MSS_ST_IDLE;
            end
            else
            begin
              state <= `MSS_ST_DECEL;
              flux_brake_o <= (stop_mode == 3'h3);
            end
          end
          else if (tick && freq < tgt_s2)
            freq <= (tgt_s2 - freq < RAMP_STEP) ? tgt_s2 : freq + RAMP_STEP;
          else if (tick && freq > tgt_s2)
            freq <= (freq - tgt_s2 < RAMP_STEP) ? tgt_s2 : freq - RAMP_STEP;
        end
        `MSS_ST_DECEL:
        begin
          // flux and power braking (modes 3 and 4) pre-empt stall prevention while decelerating
          stall_active_o <= stall_en && stop_mode != 3'h3 && stop_mode != 3'h4;
          if (stop_mode == 3'h1 && freq <= onset_freq)
          begin
            // dwell ignored here, injection takes over
            state <= `MSS_ST_BLANK;
            out_enable_o <= 1'b0;
            out_volt_o <= 16'h0000;
            timer <= blank_time;
          end
          else if (freq == 16'h0000)
          begin
            out_enable_o <= 1'b0;
            out_volt_o <= 16'h0000;
            flux_brake_o <= 1'b0;
            stall_active_o <= 1'b0;
            state <= `MSS_ST_IDLE;
          end
          else if (tick && stop_mode == 3'h4 && bus_s2 > bus_limit)
          begin
            // slope held or raised; stop time is unbounded
            if (bus_s2 - bus_limit > RAMP_STEP)
              freq <= freq + RAMP_STEP;
          end
          else if (tick)
            freq <= (freq < RAMP_STEP) ? 16'h0000 : freq - RAMP_STEP;
        end
        `MSS_ST_BLANK:
        begin
          stall_active_o <= 1'b0;
          freq <= 16'h0000;
          if (timer == 16'h0000)
          begin
            state <= `MSS_ST_BRAKE;
            inject_o <= 1'b1;
            inject_level_o <= brake_level[7:0];
            timer <= brake_time;
          end
          else if (tick)
            timer <= timer - 16'h0001;
        end
        `MSS_ST_BRAKE:
        begin
          if (timer == 16'h0000)
          begin
            inject_o <= 1'b0;
            state <= `MSS_ST_IDLE;
          end
          else if (tick)
            timer <= timer - 16'h0001;
        end
        default: state <= `MSS_ST_IDLE;
      endcase
    end
  end
endmodule

// file: design/mss_tick.v
`timescale 1ns/1ps
`include "mss_consts.vh"
module mss_tick #(
  parameter CYCLES = `MSS_TICK_CYCLES
)(
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // enable pulse
  output reg tick_o
);
  reg [31:0] count;
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count <= 32'h0000_0000;
      tick_o <= 1'b0;
    end
    else if (count == CYCLES - 1)
    begin
      count <= 32'h0000_0000;
      tick_o <= 1'b1;
    end
    else
    begin
      count <= count + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end
endmodule

// file: dv/motor_start_stop_sequencer_bench.sv
`timescale 1ns/1ps
`include "mss_consts.vh"
module motor_start_stop_sequencer_bench;
  reg clk_sys_i = 1'b0;
  reg resetn_i = 1'b0;
  reg [3:0] addr_i = 4'h0;
  reg [15:0] wdata_i = 16'h0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg run_i = 1'b0;
  reg [15:0] target_freq_i = 16'h0000;
  reg [15:0] supply_volt_i = 16'h00F0;
  wire [15:0] bus_volt_i;
  wire [15:0] rdata_o;
  wire [15:0] out_freq_o;
  wire [15:0] out_volt_o;
  wire out_enable_o;
  wire inject_o;
  wire [7:0] inject_level_o;
  wire flux_brake_o;
  wire stall_active_o;
  int n_errors = 0;
  int tests_run = 0;
  reg [15:0] v;
  reg [15:0] tgt;
  reg [7:0] plv;
  reg [7:0] blv;
  reg rose;
  int n;
  mss_sequencer #(.TICK_CYCLES(10), .RAMP_STEP(16'h0001)) dut (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .run_i(run_i), .target_freq_i(target_freq_i),
    .supply_volt_i(supply_volt_i), .bus_volt_i(bus_volt_i), .out_freq_o(out_freq_o),
    .out_volt_o(out_volt_o), .out_enable_o(out_enable_o), .inject_o(inject_o),
    .inject_level_o(inject_level_o), .flux_brake_o(flux_brake_o),
    .stall_active_o(stall_active_o));
  mss_motor_model motor (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .out_freq_i(out_freq_o),
    .out_enable_i(out_enable_o), .bus_volt_o(bus_volt_i));
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input [15:0] got, input [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input [3:0] a, input [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input [3:0] a, output [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  function automatic [15:0] clampv(input [15:0] d);
    clampv = (d == 16'h0000) ? d : (d < 16'h00B4) ? 16'h00B4 : (d > 16'h01E0) ? 16'h01E0 : d;
  endfunction
  function automatic [15:0] probe(input int sel);
    case (sel)
      0: probe = {15'h0000, out_enable_o};
      1: probe = {15'h0000, inject_o};
      2: probe = {15'h0000, flux_brake_o};
      default: probe = out_freq_o;
    endcase
  endfunction
  // bounded wait; a miss shows as a mismatch
  task automatic wait_on(input int sel, input [15:0] val);
    int k;
    k = 0;
    while (probe(sel) !== val && k < 6000)
    begin
      @(posedge clk_sys_i);
      #1 k++;
    end
    check(probe(sel), val);
  endtask
  initial
  begin
    #600000 n_errors++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'h8bd2dd4c));
    repeat (16) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(`MSS_REG_VOLT, v);
    check(v, 16'h00DC);
    rd(`MSS_REG_PRE_LEVEL, v);
    check(v, 16'h0032);
    rd(`MSS_REG_BLANK_TIME, v);
    check(v, 16'h000A);
    rd(`MSS_REG_BRAKE_TIME, v);
    check(v, 16'h0064);
    rd(`MSS_REG_BRAKE_LEVEL, v);
    check(v, 16'h0032);
    rd(`MSS_REG_ONSET_FREQ, v);
    check(v, 16'h01F4);
    rd(`MSS_REG_BASE_FREQ, v);
    check(v, 16'h1770);
    rd(`MSS_REG_BUS_LIMIT, v);
    check(v, 16'h02EE);
    for (int i = 0; i < 8; i++)
    begin
      tgt = (i < 3) ? 16'h00B4 * i : $urandom % 700;
      wr(`MSS_REG_VOLT, tgt);
      rd(`MSS_REG_VOLT, v);
      check(v, clampv(tgt));
    end
    wr(4'hE, 16'h1234);
    rd(4'hE, v);
    check(v, 16'h0000);
    wr(`MSS_REG_VOLT, 16'h00DC);
    wr(`MSS_REG_PRE_TIME, 16'h0003);
    wr(`MSS_REG_BLANK_TIME, 16'h0002);
    wr(`MSS_REG_BRAKE_TIME, 16'h0003);
    wr(`MSS_REG_ONSET_FREQ, 16'h000A);
    wr(`MSS_REG_DWELL_FREQ, 16'h0005);
    for (int m = 0; m < 5; m++)
    begin
      plv = $urandom % 201;
      blv = $urandom % 201;
      tgt = 16'h0014 + $urandom % 40;
      wr(`MSS_REG_PRE_LEVEL, {8'h00, plv});
      wr(`MSS_REG_BRAKE_LEVEL, {8'h00, blv});
      wr(`MSS_REG_CTRL, {11'h000, 1'b1, m[2:0], m[0]});
      @(posedge clk_sys_i);
      target_freq_i <= tgt;
      supply_volt_i <= 16'h00C8 + $urandom % 280;
      run_i <= 1'b1;
      if (m[0])
      begin
        wait_on(1, 1);
        check(inject_level_o, plv);
      end
      wait_on(3, tgt);
      check(out_enable_o, 1'b1);
      // below base the volts follow the frequency linearly
      check(out_volt_o, 16'h00DC * tgt / 16'h1770);
      @(posedge clk_sys_i);
      run_i <= 1'b0;
      if (m == 2)
      begin
        repeat (4) @(posedge clk_sys_i);
        #1 check(out_enable_o, 1'b0);
      end
      if (m == 0 || m == 4)
      begin
        repeat (4) @(posedge clk_sys_i);
        #1 check(stall_active_o, (m == 0));
      end
      if (m == 1)
      begin
        wait_on(0, 0);
        check(inject_o, 1'b0);
        check(out_freq_o <= 16'h000A, 1'b1);
        wait_on(1, 1);
        check(inject_level_o, blv);
        n = 0;
        while (inject_o === 1'b1 && n < 500)
        begin
          @(posedge clk_sys_i);
          #1 n++;
        end
        check(n >= 20 && n <= 31, 1'b1);
      end
      if (m == 3)
      begin
        wait_on(2, 1);
        check(stall_active_o, 1'b0);
      end
      rose = 1'b0;
      v = out_freq_o;
      n = 0;
      while (out_freq_o !== 16'h0000 && n < 8000)
      begin
        @(posedge clk_sys_i);
        #1 n++;
        if (out_freq_o > v && out_enable_o)
          rose = 1'b1;
        v = out_freq_o;
      end
      check(out_freq_o, 16'h0000);
      if (m == 4)
      begin
        check(rose, 1'b1);
        check(stall_active_o, 1'b0);
      end
      wait_on(0, 0);
      wait_on(1, 0);
      rd(`MSS_REG_STATUS, v);
      check(v[2:0], `MSS_ST_IDLE);
    end
    close_out();
  end
endmodule

// file: dv/mss_motor_model.sv
`timescale 1ns/1ps
module mss_motor_model (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // drive side
  input wire [15:0] out_freq_i,
  input wire out_enable_i,
  // measured bus
  output reg [15:0] bus_volt_o
);
  reg [15:0] last_freq;
  // regen pumps the bus faster than it leaks, so braking must back off
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bus_volt_o <= 16'h0258;
      last_freq <= 16'h0000;
    end
    else
    begin
      last_freq <= out_freq_i;
      if (out_enable_i && out_freq_i < last_freq)
        bus_volt_o <= bus_volt_o + 16'h0030;
      else if (bus_volt_o > 16'h025C)
        bus_volt_o <= bus_volt_o - 16'h0004;
    end
  end
endmodule

// file: dv/mss_seq_props.sv
`timescale 1ns/1ps
`include "mss_consts.vh"
module mss_seq_props #(
  parameter RAMP_STEP = 16'h0001
)(
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  // drive outputs
  input wire [15:0] out_freq_o,
  input wire [15:0] out_volt_o,
  input wire out_enable_o,
  input wire inject_o,
  input wire [7:0] inject_level_o,
  input wire flux_brake_o,
  input wire stall_active_o
);
  reg [15:0] vsh;
  reg [7:0] pre_lv;
  reg [7:0] brk_lv;
  // shadow settings, clamped as the register clamps them
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      vsh <= `MSS_RST_VOLT;
      pre_lv <= 8'h32;
      brk_lv <= 8'h32;
    end
    else if (wr_i && addr_i == `MSS_REG_VOLT)
      vsh <= (wdata_i == 16'h0000) ? 16'h0000 : (wdata_i < `MSS_VOLT_MIN) ? `MSS_VOLT_MIN :
        (wdata_i > `MSS_VOLT_MAX) ? `MSS_VOLT_MAX : wdata_i;
    else if (wr_i && addr_i == `MSS_REG_PRE_LEVEL)
      pre_lv <= wdata_i[7:0];
    else if (wr_i && addr_i == `MSS_REG_BRAKE_LEVEL)
      brk_lv <= wdata_i[7:0];
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_read_volt;
    rd_i && addr_i == `MSS_REG_VOLT;
  endsequence
  // output register lags a write by a cycle or two
  sequence s_vsteady;
    $stable(vsh)[*3] ##0 vsh != 16'h0000;
  endsequence
  property p_volt_rb;
    s_read_volt |=> rdata_o == vsh;
  endproperty
  a_volt_rb: assert property (p_volt_rb) else $error("voltage read-back wrong");
  property p_rd_idle;
    !rd_i |=> rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_unmap;
    rd_i && addr_i > `MSS_REG_OUT_VOLT |=> rdata_o == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_vcap;
    s_vsteady |-> out_volt_o <= vsh;
  endproperty
  a_vcap: assert property (p_vcap) else $error("output voltage above nameplate");
  property p_blocked;
    !out_enable_o && !inject_o |-> out_volt_o == 16'h0000;
  endproperty
  a_blocked: assert property (p_blocked) else $error("voltage while blocked");
  property p_ramp;
    out_enable_o && $past(out_enable_o) |-> (out_freq_o - $past(out_freq_o) <= RAMP_STEP) ||
      ($past(out_freq_o) - out_freq_o <= RAMP_STEP);
  endproperty
  a_ramp: assert property (p_ramp) else $error("frequency step too large");
  property p_flux;
    flux_brake_o |-> !stall_active_o;
  endproperty
  a_flux: assert property (p_flux) else $error("stall active in flux braking");
  property p_inj_lvl;
    inject_o |-> inject_level_o == pre_lv || inject_level_o == brk_lv;
  endproperty
  a_inj_lvl: assert property (p_inj_lvl) else $error("injection level wrong");
endmodule
bind mss_sequencer mss_seq_props #(.RAMP_STEP(RAMP_STEP)) u_props (.clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .out_freq_o(out_freq_o), .out_volt_o(out_volt_o),
  .out_enable_o(out_enable_o), .inject_o(inject_o), .inject_level_o(inject_level_o),
  .flux_brake_o(flux_brake_o), .stall_active_o(stall_active_o));
